/* File: design/afm_top.sv */
// flag merge and startup control for the converter
`timescale 1ns/1ps
`default_nettype none
module afm_top
   import afm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // conversion core events, one-cycle pulses
   input wire logic seq_a_conv_done,
   input wire logic seq_b_conv_done,
   input wire logic seq_a_pass_done,
   input wire logic seq_b_pass_done,
   input wire logic seq_a_overrun,
   input wire logic seq_b_overrun,
   input wire logic [NUM_CH-1:0] ch_overrun_set,
   input wire logic [NUM_CH-1:0] ch_result_read,
   input wire logic [2*NUM_CH-1:0] ch_threshold_hit,
   input wire logic trim_done,
   input wire logic dummy_done,
   // power (pin domain)
   input wire logic converter_powered,
   // core control
   output logic converter_enable,
   output logic dummy_start,
   output logic trim_reload,
   output logic trim_needed_status,
   // interrupts and dma
   output logic seq_a_irq,
   output logic seq_b_irq,
   output logic thr_ovr_irq,
   output logic seq_a_dma,
   output logic seq_b_dma
);
   // ------------------------------------------------------------
   // power pin synchroniser
   // ------------------------------------------------------------
   logic [2:0] pwr_q;
   logic [2:0] pwr_d;
   logic pwr_lvl_q;
   logic pwr_lvl_d;

   always_comb begin
      pwr_d = {pwr_q[1:0], converter_powered};
      pwr_lvl_d = pwr_lvl_q;
      // change counted once stages two and three agree
      if (pwr_q[1] == pwr_q[2]) begin
         pwr_lvl_d = pwr_q[2];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pwr_q <= 3'h0;
         pwr_lvl_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         pwr_lvl_q <= pwr_lvl_d;
      end
   end

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic acc;
   logic wr;
   logic rd;
   assign acc = psel && penable;
   assign wr = acc && pwrite && pready;
   assign rd = acc && !pwrite && pready;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a[11:2] == o[11:2]);
   endfunction : hit

   logic wr_flags;
   logic wr_start;
   logic rd_gdat_a;
   logic rd_gdat_b;
   assign wr_flags = wr && hit(paddr, FLAGS_OFS);
   assign wr_start = wr && hit(paddr, STARTUP_OFS);
   assign rd_gdat_a = rd && hit(paddr, RES_A_OFS);
   assign rd_gdat_b = rd && hit(paddr, RES_B_OFS);

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   logic [31:0] irq_en_q;
   logic [31:0] irq_en_d;
   logic [2:0] ctl_q;
   logic [2:0] ctl_d;
   logic mode_a;
   logic mode_b;
   assign mode_a = ctl_q[CTL_MODE_A_BIT];
   assign mode_b = ctl_q[CTL_MODE_B_BIT];

   always_comb begin
      irq_en_d = irq_en_q;
      ctl_d = ctl_q;
      if (wr && hit(paddr, IRQ_EN_OFS)) begin
         irq_en_d = pwdata;
      end
      if (wr && hit(paddr, CTRL_OFS)) begin
         ctl_d = pwdata[2:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_en_q <= IRQ_EN_RST;
         ctl_q <= 3'h0;
      end else begin
         irq_en_q <= irq_en_d;
         ctl_q <= ctl_d;
      end
   end

   // ------------------------------------------------------------
   // per-channel flags
   // ------------------------------------------------------------
   logic [NUM_CH-1:0] thr_flag;
   logic [NUM_CH-1:0] ovr_flag;
   logic [NUM_CH-1:0] thr_set;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         // each comparison type enabled on its own
         assign thr_set[g] =
            (ch_threshold_hit[2*g] && irq_en_q[IE_THR_LSB+2*g]) ||
            (ch_threshold_hit[2*g+1] && irq_en_q[IE_THR_LSB+2*g+1]);
         afm_flag u_thr (
            .sys_clk(sys_clk),
            .rst(rst),
            .set_i(thr_set[g]),
            .clr_i(wr_flags && pwdata[g]),
            .flag_o(thr_flag[g])
         );
         afm_flag u_ovr (
            .sys_clk(sys_clk),
            .rst(rst),
            .set_i(ch_overrun_set[g]),
            .clr_i(ch_result_read[g]),
            .flag_o(ovr_flag[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // global result flags
   // ------------------------------------------------------------
   logic valid_a;
   logic valid_b;
   logic gov_a;
   logic gov_b;
   logic pass_a;
   logic pass_b;

   afm_flag u_va (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_i(seq_a_conv_done),
      .clr_i(rd_gdat_a),
      .flag_o(valid_a)
   );
   afm_flag u_vb (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_i(seq_b_conv_done),
      .clr_i(rd_gdat_b),
      .flag_o(valid_b)
   );
   afm_flag u_oa (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_i(seq_a_overrun),
      .clr_i(rd_gdat_a),
      .flag_o(gov_a)
   );
   afm_flag u_ob (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_i(seq_b_overrun),
      .clr_i(rd_gdat_b),
      .flag_o(gov_b)
   );
   afm_flag u_pa (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_i(seq_a_pass_done && mode_a),
      .clr_i(wr_flags && pwdata[SUM_A_BIT]),
      .flag_o(pass_a)
   );
   afm_flag u_pb (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_i(seq_b_pass_done && mode_b),
      .clr_i(wr_flags && pwdata[SUM_B_BIT]),
      .flag_o(pass_b)
   );

   // ------------------------------------------------------------
   // summary flags
   // ------------------------------------------------------------
   logic sum_a;
   logic sum_b;
   logic sum_thr;
   logic sum_ovr;
   assign sum_a = mode_a ? pass_a : valid_a;
   assign sum_b = mode_b ? pass_b : valid_b;
   assign sum_thr = |thr_flag;
   assign sum_ovr = (|ovr_flag) || (gov_a && !mode_a) ||
      (gov_b && !mode_b);

   // ------------------------------------------------------------
   // startup control
   // ------------------------------------------------------------
   logic ena_q;
   logic ena_d;
   logic init_q;
   logic init_d;
   logic trimmed_q;
   logic trimmed_d;
   logic [3:0] dcnt_q;
   logic [3:0] dcnt_d;
   logic reload_d;
   afm_init_e st_q;
   afm_init_e st_d;

   always_comb begin
      ena_d = ena_q;
      init_d = init_q;
      trimmed_d = trimmed_q;
      st_d = st_q;
      dcnt_d = dcnt_q;
      reload_d = 1'b0;
      // setting only; zeros written do nothing
      if (wr_start && pwdata[ENA_BIT]) begin
         ena_d = 1'b1;
      end
      if (trim_done) begin
         trimmed_d = 1'b1;
      end
      case (st_q)
         AFM_IDLE: begin
            // init ignored unless already enabled
            if (wr_start && pwdata[INIT_BIT] && ena_q) begin
               init_d = 1'b1;
               reload_d = !ctl_q[CTL_SKIP_BIT];
               st_d = AFM_DUMMY;
               dcnt_d = DUMMY_CYC;
            end
         end
         AFM_DUMMY: begin
            // core end or local count, whichever first
            if (dummy_done || dcnt_q == 4'h1) begin
               init_d = 1'b0;
               st_d = AFM_IDLE;
            end else begin
               dcnt_d = dcnt_q - 4'h1;
            end
         end
         default: begin
            st_d = AFM_IDLE;
         end
      endcase
      if (!pwr_lvl_q) begin
         ena_d = 1'b0;
         init_d = 1'b0;
         trimmed_d = 1'b0;
         st_d = AFM_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ena_q <= STARTUP_RST[ENA_BIT];
         init_q <= STARTUP_RST[INIT_BIT];
         trimmed_q <= 1'b0;
         st_q <= AFM_IDLE;
         dcnt_q <= 4'h0;
         trim_reload <= 1'b0;
      end else begin
         ena_q <= ena_d;
         init_q <= init_d;
         trimmed_q <= trimmed_d;
         st_q <= st_d;
         dcnt_q <= dcnt_d;
         trim_reload <= reload_d;
      end
   end

   // ------------------------------------------------------------
   // read mux and registered outputs
   // ------------------------------------------------------------
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit(paddr, FLAGS_OFS)) begin
         rdata_d[NUM_CH-1:0] = thr_flag;
         rdata_d[OVR_LSB +: NUM_CH] = ovr_flag;
         rdata_d[SEQA_OVR_BIT] = gov_a;
         rdata_d[SEQB_OVR_BIT] = gov_b;
         rdata_d[SUM_A_BIT] = sum_a;
         rdata_d[SUM_B_BIT] = sum_b;
         rdata_d[SUM_THR_BIT] = sum_thr;
         rdata_d[SUM_OVR_BIT] = sum_ovr;
      end else if (hit(paddr, STARTUP_OFS)) begin
         rdata_d[ENA_BIT] = ena_q;
         rdata_d[INIT_BIT] = init_q;
      end else if (hit(paddr, IRQ_EN_OFS)) begin
         rdata_d = irq_en_q;
      end else if (hit(paddr, CTRL_OFS)) begin
         rdata_d[2:0] = ctl_q;
      end else if (hit(paddr, STATUS_OFS)) begin
         rdata_d[0] = !trimmed_q && !ctl_q[CTL_SKIP_BIT];
      end else if (hit(paddr, RES_A_OFS)) begin
         rdata_d[31] = valid_a;
         rdata_d[30] = gov_a;
      end else if (hit(paddr, RES_B_OFS)) begin
         rdata_d[31] = valid_b;
         rdata_d[30] = gov_b;
      end
   end

   logic mapped;
   assign mapped = hit(paddr, FLAGS_OFS) || hit(paddr, STARTUP_OFS) ||
      hit(paddr, IRQ_EN_OFS) || hit(paddr, CTRL_OFS) ||
      hit(paddr, STATUS_OFS) || hit(paddr, RES_A_OFS) ||
      hit(paddr, RES_B_OFS);

   // one wait state; writes and read clears land once, with pready
   logic rdy_d;
   assign rdy_d = psel && penable && !pready;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         converter_enable <= 1'b0;
         dummy_start <= 1'b0;
         trim_needed_status <= 1'b0;
         seq_a_irq <= 1'b0;
         seq_b_irq <= 1'b0;
         thr_ovr_irq <= 1'b0;
         seq_a_dma <= 1'b0;
         seq_b_dma <= 1'b0;
      end else begin
         prdata <= psel ? rdata_d : 32'h0000_0000;
         pready <= rdy_d;
         pslverr <= rdy_d && !mapped;
         converter_enable <= ena_d;
         dummy_start <= init_d;
         trim_needed_status <= !trimmed_d && !ctl_d[CTL_SKIP_BIT];
         seq_a_irq <= sum_a && irq_en_q[IE_SEQA_BIT];
         seq_b_irq <= sum_b && irq_en_q[IE_SEQB_BIT];
         // threshold needs no extra gate: events already enabled
         thr_ovr_irq <= sum_thr ||
            (sum_ovr && irq_en_q[IE_OVR_BIT]);
         seq_a_dma <= sum_a;
         seq_b_dma <= sum_b;
      end
   end
endmodule : afm_top
`default_nettype wire

/* File: design/afm_pkg.sv */
// constants and register layout for the converter flag merge and startup block
package afm_pkg;
   localparam int unsigned NUM_CH = 12;
   // byte addresses
   localparam logic [11:0] FLAGS_OFS = 12'h068;
   localparam logic [11:0] STARTUP_OFS = 12'h06C;
   localparam logic [11:0] IRQ_EN_OFS = 12'h064;
   localparam logic [11:0] RES_A_OFS = 12'h010;
   localparam logic [11:0] RES_B_OFS = 12'h014;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h074;
   // flag register fields
   localparam int unsigned OVR_LSB = 12;
   localparam int unsigned SEQA_OVR_BIT = 24;
   localparam int unsigned SEQB_OVR_BIT = 25;
   localparam int unsigned SUM_A_BIT = 28;
   localparam int unsigned SUM_B_BIT = 29;
   localparam int unsigned SUM_THR_BIT = 30;
   localparam int unsigned SUM_OVR_BIT = 31;
   // startup fields
   localparam int unsigned ENA_BIT = 0;
   localparam int unsigned INIT_BIT = 1;
   // interrupt enable fields
   localparam int unsigned IE_SEQA_BIT = 0;
   localparam int unsigned IE_SEQB_BIT = 1;
   localparam int unsigned IE_THR_LSB = 3;
   localparam int unsigned IE_OVR_BIT = 2;
   // control fields (own register)
   localparam int unsigned CTL_MODE_A_BIT = 0;
   localparam int unsigned CTL_MODE_B_BIT = 1;
   localparam int unsigned CTL_SKIP_BIT = 2;
   // reset values
   localparam logic [31:0] STARTUP_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;
   // timing
   localparam int unsigned CLK_MHZ = 20;
   localparam int unsigned POWERUP_WAIT_US = 10;
   localparam int unsigned POWERUP_WAIT_CYC = POWERUP_WAIT_US * CLK_MHZ;
   localparam logic [3:0] DUMMY_CYC = 4'h6;
   typedef enum logic [1:0] {AFM_IDLE, AFM_RELOAD, AFM_DUMMY} afm_init_e;
endpackage : afm_pkg

/* File: design/afm_flag.sv */
// one sticky flag cell: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module afm_flag
   import afm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic set_i,
   input wire logic clr_i,
   // state
   output logic flag_o
);
   logic flag_q;
   logic flag_d;

   always_comb begin
      flag_d = flag_q;
      if (clr_i) begin
         flag_d = 1'b0;
      end
      if (set_i) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
endmodule : afm_flag
`default_nettype wire

/* File: sim/afm_chk_assertions.sv */
// port level checks for the flag merge and startup block
`timescale 1ns/1ps
`default_nettype none
module afm_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // inputs seen
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic converter_powered,
   input wire logic dummy_done,
   input wire logic trim_done,
   input wire logic seq_a_conv_done,
   input wire logic seq_a_pass_done,
   // outputs watched
   input wire logic converter_enable,
   input wire logic dummy_start,
   input wire logic trim_reload,
   input wire logic trim_needed_status,
   input wire logic seq_a_irq,
   input wire logic seq_a_dma
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // -------------------------------------------
   // startup sequence
   // -------------------------------------------
   sequence s_drop_clear;
      ##[1:5] (!converter_enable && !dummy_start);
   endsequence
   sequence s_dummy_end;
      ##[1:7] !dummy_start;
   endsequence
   a_enable_power_off:
   assert property ($fell(converter_powered) |-> s_drop_clear)
      else $error("enable not cleared at power down");
   a_enable_by_write:
   assert property ($rose(converter_enable)
      |-> $past(psel && penable && pwrite))
      else $error("enable set without a write");
   a_init_by_write:
   assert property ($rose(dummy_start)
      |-> $past(psel && penable && pwrite && converter_enable))
      else $error("init started without enabled write");
   a_init_self_clear:
   assert property ($rose(dummy_start) |-> s_dummy_end)
      else $error("init not cleared after dummy cycle");
   a_done_clears_init:
   assert property (dummy_start && dummy_done |-> ##[1:2] !dummy_start)
      else $error("init kept after dummy done");
   a_reload_with_init:
   assert property (trim_reload |=> !trim_reload && dummy_start)
      else $error("trim reload outside init");
   a_trim_status:
   assert property (trim_done |-> ##[1:2] !trim_needed_status)
      else $error("trim needed kept after trim");
   // -------------------------------------------
   // summary flags
   // -------------------------------------------
   a_irq_needs_flag:
   assert property (seq_a_irq |-> seq_a_dma)
      else $error("irq without sequence flag");
   a_dma_cause:
   assert property ($rose(seq_a_dma)
      |-> $past(seq_a_conv_done, 2) || $past(seq_a_pass_done, 2))
      else $error("dma request without event");
endmodule : afm_chk
bind afm_top afm_chk i_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .dummy_done(dummy_done),
   .converter_powered(converter_powered), .trim_done(trim_done),
   .seq_a_conv_done(seq_a_conv_done), .seq_a_pass_done(seq_a_pass_done),
   .converter_enable(converter_enable), .dummy_start(dummy_start),
   .trim_reload(trim_reload), .trim_needed_status(trim_needed_status),
   .seq_a_irq(seq_a_irq), .seq_a_dma(seq_a_dma));
`default_nettype wire

/* File: sim/afm_core_model.sv */
// behavioural conversion core answering dummy cycles and trims
`timescale 1ns/1ps
`default_nettype none
module afm_core_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // from block and bench
   input wire logic dummy_start,
   input wire logic [3:0] dummy_lat,
   input wire logic trim_go,
   // answers
   output logic dummy_done,
   output logic trim_done
);
   logic [3:0] cnt;
   logic [2:0] trim_sr;
   // latency from the bench: a large one lets the block time out
   always_ff @(posedge sys_clk) begin
      if (rst || !dummy_start)
         cnt <= 4'h0;
      else if (cnt != 4'hF)
         cnt <= cnt + 4'h1;
      dummy_done <= !rst && dummy_start && cnt == dummy_lat;
      trim_sr <= rst ? 3'h0 : {trim_sr[1:0], trim_go};
      trim_done <= !rst && trim_sr[2];
   end
endmodule : afm_core_model
`default_nettype wire

/* File: sim/tb_afm_top.sv */
// self-checking bench for the flag merge and startup block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_afm_top
   import afm_pkg::*;
;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0, ovr_set = '0, res_rd = '0;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic [23:0] thr = '0;
   logic [5:0] ev = '0;
   logic [3:0] lat = 4'h1;
   logic pready, pslverr, rerr, pwr = 0, trim_go = 0, ddone, tdone;
   logic en, dstart, dreload, tneed, irq_a, irq_b, irq_t, dma_a, dma_b;
   int bad_count = 0, compares = 0, reload_n = 0;
   afm_top i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seq_a_conv_done(ev[0]), .seq_b_conv_done(ev[1]),
      .seq_a_pass_done(ev[2]), .seq_b_pass_done(ev[3]),
      .seq_a_overrun(ev[4]), .seq_b_overrun(ev[5]),
      .ch_overrun_set(ovr_set), .ch_result_read(res_rd),
      .ch_threshold_hit(thr), .trim_done(tdone), .dummy_done(ddone),
      .converter_powered(pwr), .converter_enable(en), .dummy_start(dstart),
      .trim_reload(dreload), .trim_needed_status(tneed),
      .seq_a_irq(irq_a), .seq_b_irq(irq_b), .thr_ovr_irq(irq_t),
      .seq_a_dma(dma_a), .seq_b_dma(dma_b));
   afm_core_model i_core (.sys_clk(sys_clk), .rst(rst), .dummy_start(dstart),
      .dummy_lat(lat), .trim_go(trim_go), .dummy_done(ddone),
      .trim_done(tdone));
   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (dreload === 1'b1)
         reload_n <= reload_n + 1;
   // -------------------------------------------
   // bus and event tasks
   // -------------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20)
         bad_count++;
   endtask : apb
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task chk_flags(input logic [31:0] e);
      rd(FLAGS_OFS);
      `CHK("flags", e, rdat)
   endtask : chk_flags
   task fire(input int k);
      @(posedge sys_clk);
      ev[k] <= 1;
      @(posedge sys_clk);
      ev <= '0;
   endtask : fire
   task pv(input logic [23:0] t, input logic [11:0] o, input logic [11:0] r);
      @(posedge sys_clk);
      thr <= t;
      ovr_set <= o;
      res_rd <= r;
      @(posedge sys_clk);
      thr <= '0;
      ovr_set <= '0;
      res_rd <= '0;
      cyc(2);
   endtask : pv
   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   task t_reset;
      rd(STARTUP_OFS);
      `CHK("startup", STARTUP_RST, rdat)
      rd(IRQ_EN_OFS);
      `CHK("irq_en", IRQ_EN_RST, rdat)
      chk_flags(32'h0);
      rd(12'h0F0);
      `CHK("unmapped", 1'b1, rerr)
      rd(STATUS_OFS);
      `CHK("need", 32'h1, rdat & 32'h1)
      apb(1'b1, STARTUP_OFS, 32'h1);
      cyc(5);
      `CHK("ena unpowered", 1'b0, en)
      $display("test reset done");
   endtask : t_reset
   task t_start;
      pwr <= 1;
      cyc(POWERUP_WAIT_CYC);
      apb(1'b1, STARTUP_OFS, 32'h1);
      apb(1'b1, STARTUP_OFS, 32'h0);
      cyc(2);
      `CHK("enable", 1'b1, en)
      apb(1'b1, STARTUP_OFS, 32'h2);
      cyc(4);
      `CHK("dummy quick", 1'b0, dstart)
      `CHK("reload", 1, reload_n)
      lat <= 4'hC;
      apb(1'b1, STARTUP_OFS, 32'h2);
      cyc(4);
      `CHK("dummy slow", 1'b1, dstart)
      cyc(6);
      `CHK("dummy end", 1'b0, dstart)
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_SKIP_BIT);
      apb(1'b1, STARTUP_OFS, 32'h2);
      cyc(8);
      `CHK("reload skip", 2, reload_n)
      `CHK("need skip", 1'b0, tneed)
      apb(1'b1, CTRL_OFS, 32'h0);
      cyc(2);
      `CHK("need", 1'b1, tneed)
      trim_go <= 1;
      @(posedge sys_clk);
      trim_go <= 0;
      cyc(6);
      `CHK("need trimmed", 1'b0, tneed)
      pwr <= 0;
      cyc(8);
      `CHK("ena off", 1'b0, en)
      `CHK("need again", 1'b1, tneed)
      $display("test startup done");
   endtask : t_start
   task t_seq;
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, IRQ_EN_OFS, 32'h0);
         apb(1'b1, CTRL_OFS, 32'h0);
         fire(s);
         cyc(3);
         chk_flags(32'h1 << (28 + s));
         `CHK("dma", 1'b1, s ? dma_b : dma_a)
         `CHK("irq masked", 1'b0, s ? irq_b : irq_a)
         apb(1'b1, IRQ_EN_OFS, 32'h1 << s);
         cyc(2);
         `CHK("irq", 1'b1, s ? irq_b : irq_a)
         rd(RES_A_OFS + 12'(4 * s));
         `CHK("result", 2'b10, rdat[31:30])
         chk_flags(32'h0);
         apb(1'b1, CTRL_OFS, 32'h3);
         fire(s);
         cyc(3);
         chk_flags(32'h0);
         fire(2 + s);
         cyc(3);
         rd(RES_A_OFS + 12'(4 * s));
         chk_flags(32'h1 << (28 + s));
         apb(1'b1, FLAGS_OFS, 32'h1 << (28 + s));
         chk_flags(32'h0);
      end
      $display("test sequences done");
   endtask : t_seq
   task t_thr_ovr;
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, IRQ_EN_OFS, 32'h0);
      pv(24'h000040, 12'h0, 12'h0);
      chk_flags(32'h0);
      apb(1'b1, IRQ_EN_OFS, 32'h0000_4200);
      pv(24'h0008C0, 12'h0, 12'h0);
      chk_flags(32'h4000_0028);
      `CHK("thr irq", 1'b1, irq_t)
      apb(1'b1, FLAGS_OFS, 32'h8);
      chk_flags(32'h4000_0020);
      apb(1'b1, FLAGS_OFS, 32'h20);
      chk_flags(32'h0);
      apb(1'b1, IRQ_EN_OFS, 32'h1 << IE_OVR_BIT);
      pv(24'h0, 12'h080, 12'h0);
      chk_flags(32'h8008_0000);
      `CHK("ovr irq", 1'b1, irq_t)
      apb(1'b1, IRQ_EN_OFS, 32'h0);
      cyc(2);
      `CHK("ovr masked", 1'b0, irq_t)
      pv(24'h0, 12'h0, 12'h080);
      chk_flags(32'h0);
      // sequence a then sequence b global overrun
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, CTRL_OFS, 32'h1 << s);
         fire(4 + s);
         cyc(2);
         chk_flags(32'h0100_0000 << s);
         rd(RES_A_OFS + 12'(4 * s));
         apb(1'b1, CTRL_OFS, 32'h0);
         fire(4 + s);
         cyc(2);
         chk_flags(32'h8000_0000 | (32'h0100_0000 << s));
         rd(RES_A_OFS + 12'(4 * s));
         chk_flags(32'h0);
      end
      $display("test threshold and overrun done");
   endtask : t_thr_ovr
   task final_report;
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      cyc(12);
      rst <= 0;
      t_reset;
      t_start;
      t_seq;
      t_thr_ovr;
      final_report;
   end
   // tests need about six hundred cycles, so this is a hang
   initial begin
      cyc(5000);
      bad_count++;
      final_report;
   end
endmodule : tb_afm_top
`default_nettype wire
